//--- core/fsp_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
// Run-time self-program sequencer register block and operation control.
module fsp_sequencer
   import fsp_pkg::*;
#(
   parameter int ERASE_CNT = ERASE_CYCLES,
   parameter int PROGRAM_CNT = PROGRAM_CYCLES
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Register port.
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // Processor and flash array.
   output logic cpu_stall,
   output logic flash_erase,
   output logic flash_program,
   output logic [EA_W-1:0] flash_addr,
   output logic [2*WORD_W-1:0] flash_wdata
);
   //---------------------------------------------------------------------------
   // Registers
   //---------------------------------------------------------------------------
   logic [DATA_W-1:0] flash_op_control;
   logic [7:0] flash_addr_high;
   logic [DATA_W-1:0] flash_addr_low;
   logic [WORD_W-1:0] word0;
   logic [WORD_W-1:0] word1;
   fsp_key_t key_state;
   fsp_op_t op_state;
   logic [DATA_W-1:0] rdata_q;
   fsp_flash_if fl ();

   //---------------------------------------------------------------------------
   // Decode
   //---------------------------------------------------------------------------
   wire logic wr_ctl = reg_wr && (reg_addr == OFS_CONTROL);
   wire logic wr_key = reg_wr && (reg_addr == OFS_KEY);
   wire logic wr_ah = reg_wr && (reg_addr == OFS_ADDR_HIGH);
   wire logic wr_al = reg_wr && (reg_addr == OFS_ADDR_LOW);
   wire logic wr_d0l = reg_wr && (reg_addr == OFS_DATA0_LOW);
   wire logic wr_d0h = reg_wr && (reg_addr == OFS_DATA0_HIGH);
   wire logic wr_d1l = reg_wr && (reg_addr == OFS_DATA1_LOW);
   wire logic wr_d1h = reg_wr && (reg_addr == OFS_DATA1_HIGH);
   wire logic [7:0] key_val = reg_wdata[7:0];
   wire logic [CTL_OP_W-1:0] op_sel = reg_wdata[CTL_OP_LSB +: CTL_OP_W];
   wire logic [EA_W-1:0] effective_target_address = {flash_addr_high, flash_addr_low};
   wire logic busy = (op_state != OP_IDLE);
   wire logic start_req = wr_ctl && reg_wdata[CTL_START_BIT] && !busy;
   wire logic unlocked = (key_state == ST_ARM2);
   // A pair must start on the odd word address of an aligned word pair.
   wire logic pair_aligned = effective_target_address[1:0] == 2'b10;
   wire logic op_valid = (op_sel == OP_ERASE_PAGE) || ((op_sel == OP_PROGRAM_PAIR) && pair_aligned);
   wire logic go = start_req && unlocked && op_valid;
   wire logic go_erase = go && (op_sel == OP_ERASE_PAGE);

   assign fl.start = go;
   assign fl.is_erase = go_erase;
   assign fl.cycles = go_erase ? CNT_W'(ERASE_CNT) : CNT_W'(PROGRAM_CNT);

   fsp_timer u_timer (
      .mclk(mclk),
      .rst(rst),
      .fl(fl)
   );

   //---------------------------------------------------------------------------
   // Unlock sequence
   //---------------------------------------------------------------------------
   // Any write that is not the next expected key, including a start, disarms.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         key_state <= ST_IDLE;
      end else if (reg_wr) begin
         case (key_state)
            ST_IDLE: key_state <= (wr_key && key_val == KEY_FIRST) ? ST_ARM1 : ST_IDLE;
            ST_ARM1: key_state <= (wr_key && key_val == KEY_SECOND) ? ST_ARM2 : ST_IDLE;
            default: key_state <= (wr_key && key_val == KEY_FIRST) ? ST_ARM1 : ST_IDLE;
         endcase
      end
   end

   //---------------------------------------------------------------------------
   // Control, address and data registers
   //---------------------------------------------------------------------------
   // While busy the processor is stalled, so writes then are not expected;
   // they are ignored to keep the operation's address and data stable.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         flash_op_control <= CONTROL_RESET;
         op_state <= OP_IDLE;
      end else if (busy) begin
         if (fl.done) begin
            flash_op_control[CTL_START_BIT] <= 1'b0;
            op_state <= OP_IDLE;
         end
      end else if (wr_ctl) begin
         flash_op_control <= '0;
         flash_op_control[CTL_OP_LSB +: CTL_OP_W] <= op_sel;
         flash_op_control[CTL_START_BIT] <= go;
         flash_op_control[CTL_ERR_BIT] <= start_req && !go;
         if (go) begin
            op_state <= go_erase ? OP_ERASE : OP_PROGRAM;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         flash_addr_high <= '0;
         flash_addr_low <= '0;
         word0 <= '0;
         word1 <= '0;
      end else if (!busy) begin
         if (wr_ah) flash_addr_high <= reg_wdata[7:0];
         if (wr_al) flash_addr_low <= reg_wdata;
         if (wr_d0l) word0[15:0] <= reg_wdata;
         if (wr_d0h) word0[23:16] <= reg_wdata[7:0];
         if (wr_d1l) word1[15:0] <= reg_wdata;
         if (wr_d1h) word1[23:16] <= reg_wdata[7:0];
      end
   end

   //---------------------------------------------------------------------------
   // Read-back
   //---------------------------------------------------------------------------
   wire logic [DATA_W-1:0] rd_mux =
      (reg_addr == OFS_CONTROL) ? flash_op_control :
      (reg_addr == OFS_ADDR_HIGH) ? {8'h00, flash_addr_high} :
      (reg_addr == OFS_ADDR_LOW) ? flash_addr_low :
      (reg_addr == OFS_DATA0_LOW) ? word0[15:0] :
      (reg_addr == OFS_DATA0_HIGH) ? {8'h00, word0[23:16]} :
      (reg_addr == OFS_DATA1_LOW) ? word1[15:0] :
      (reg_addr == OFS_DATA1_HIGH) ? {8'h00, word1[23:16]} :
      16'h0000;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) rdata_q <= '0;
      else if (reg_rd) rdata_q <= rd_mux;
      else rdata_q <= '0;
   end

   assign reg_rdata = rdata_q;
   assign cpu_stall = busy;
   assign flash_erase = (op_state == OP_ERASE);
   assign flash_program = (op_state == OP_PROGRAM);
   assign flash_addr = effective_target_address;
   assign flash_wdata = {word1, word0};
endmodule : fsp_sequencer
`default_nettype wire

//--- core/fsp_timer.sv
`timescale 1ns/10ps
`default_nettype none
// Counts out the array busy time of one operation and pulses done at its end.
module fsp_timer
   import fsp_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Sequencer side.
   fsp_flash_if.eng fl
);
   logic [CNT_W-1:0] remain;
   logic running;
   logic done_q;
   assign fl.busy = running;
   assign fl.done = done_q;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         remain <= '0;
         running <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (!running && fl.start) begin
            remain <= fl.cycles;
            running <= 1'b1;
         end else if (running) begin
            if (remain <= CNT_W'(1)) begin
               running <= 1'b0;
               done_q <= 1'b1;
            end else begin
               remain <= remain - CNT_W'(1);
            end
         end
      end
   end
endmodule : fsp_timer
`default_nettype wire

//--- shared/fsp_flash_if.sv
`timescale 1ns/10ps
`default_nettype none
// Request path from the sequencer to the timing engine.
interface fsp_flash_if;
   import fsp_pkg::*;
   logic start;
   logic is_erase;
   logic [CNT_W-1:0] cycles;
   logic busy;
   logic done;
   modport seq (output start, output is_erase, output cycles, input busy, input done);
   modport eng (input start, input is_erase, input cycles, output busy, output done);
endinterface : fsp_flash_if
`default_nettype wire

//--- shared/fsp_pkg.sv
//------------------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------------------
package fsp_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int EA_W = 24;
   localparam int WORD_W = 24;
   // Register offsets.
   localparam logic [3:0] OFS_CONTROL = 4'h0;
   localparam logic [3:0] OFS_KEY = 4'h2;
   localparam logic [3:0] OFS_ADDR_HIGH = 4'h4;
   localparam logic [3:0] OFS_ADDR_LOW = 4'h6;
   localparam logic [3:0] OFS_DATA0_LOW = 4'h8;
   localparam logic [3:0] OFS_DATA0_HIGH = 4'ha;
   localparam logic [3:0] OFS_DATA1_LOW = 4'hc;
   localparam logic [3:0] OFS_DATA1_HIGH = 4'he;
   // Control register fields.
   localparam int CTL_START_BIT = 15;
   localparam int CTL_ERR_BIT = 13;
   localparam int CTL_OP_LSB = 0;
   localparam int CTL_OP_W = 4;
   localparam logic [3:0] OP_PROGRAM_PAIR = 4'h1;
   localparam logic [3:0] OP_ERASE_PAGE = 4'h3;
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   // Unlock key values.
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;
   // Operation timing in microseconds at the 40 MHz clock.
   localparam int CLK_MHZ = 40;
   localparam int ERASE_TIME_US = 20000;
   localparam int PROGRAM_TIME_US = 50;
   localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
   localparam int PROGRAM_CYCLES = PROGRAM_TIME_US * CLK_MHZ;
   localparam int CNT_W = 24;
   typedef enum logic [1:0] {ST_IDLE, ST_ARM1, ST_ARM2} fsp_key_t;
   typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_PROGRAM} fsp_op_t;
endpackage : fsp_pkg

//--- tb/fsp_sequencer_bench.sv
`timescale 1ns/10ps
`default_nettype none
module fsp_sequencer_bench;
   import fsp_pkg::*;
   logic mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, cpu_stall, flash_erase, flash_program;
   logic [3:0] reg_addr = '0;
   logic [15:0] reg_wdata = '0, reg_rdata, hi, lo;
   logic [15:0] d [4];
   logic [23:0] flash_addr;
   logic [47:0] flash_wdata;
   int error_cnt = 0, comparisons = 0;
   localparam int ERASE_RUN = 20;
   localparam int PROGRAM_RUN = 5;
   initial forever #12.5 mclk = ~mclk;
   fsp_sequencer #(.ERASE_CNT(ERASE_RUN), .PROGRAM_CNT(PROGRAM_RUN)) i_dut (.mclk(mclk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .cpu_stall(cpu_stall), .flash_erase(flash_erase),
      .flash_program(flash_program), .flash_addr(flash_addr), .flash_wdata(flash_wdata));
   // ----
   // Bus cycles and comparison.
   // ----
   task automatic stop_test();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic acc(input logic w, input logic r, input logic [3:0] a, input logic [15:0] v);
      @(posedge mclk);
      {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, r, a, v};
      // Return just after the edge so that callers compare settled outputs.
      #1;
   endtask : acc
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      acc(0, 1, a, 16'h0);
      acc(0, 0, 4'h0, 16'h0);
      chk(48'(reg_rdata), 48'(exp));
   endtask : rd
   function automatic logic [47:0] wexp();
      return {d[3][7:0], d[2], d[1][7:0], d[0]};
   endfunction : wexp
   // Keys, optional intervening write, start, then wait out the operation.
   task automatic go(input logic [15:0] k1, k2, input logic mid, input logic [3:0] op,
                     input logic ok);
      int i;
      acc(1, 0, OFS_KEY, k1);
      acc(1, 0, OFS_KEY, k2);
      if (mid) acc(1, 0, OFS_ADDR_LOW, lo);
      acc(1, 0, OFS_CONTROL, 16'h8000 | 16'(op));
      acc(0, 0, 4'h0, 16'h0);
      chk(48'(cpu_stall), 48'(ok));
      chk(48'(flash_erase), 48'(ok && op == OP_ERASE_PAGE));
      chk(48'(flash_program), 48'(ok && op == OP_PROGRAM_PAIR));
      if (ok) acc(1, 0, OFS_ADDR_LOW, ~lo);
      for (i = 0; i < 40 && cpu_stall; i++) acc(0, 0, 4'h0, 16'h0);
      if (cpu_stall) begin
         error_cnt++;
         stop_test();
      end
      // The stall stands count plus one cycles, and the loop starts one cycle into it.
      chk(48'(i), ok ? 48'(op == OP_ERASE_PAGE ? ERASE_RUN : PROGRAM_RUN) : 48'h0);
      chk(48'(flash_addr), 48'({hi[7:0], lo}));
      rd(OFS_CONTROL, ok ? 16'(op) : 16'h2000 | 16'(op));
   endtask : go
   // ----
   // Main sequence.
   // ----
   initial begin
      void'($urandom(81998));
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      rd(OFS_CONTROL, CONTROL_RESET);
      acc(1, 0, OFS_KEY, 16'h0055);
      rd(OFS_KEY, 16'h0);
      rd(4'h1, 16'h0);
      repeat (3) begin
         hi = 16'($urandom);
         lo = 16'($urandom) & 16'hfffc | 16'h0002;
         foreach (d[k]) d[k] = 16'($urandom);
         acc(1, 0, OFS_ADDR_HIGH, hi);
         acc(1, 0, OFS_ADDR_LOW, lo);
         foreach (d[k]) acc(1, 0, OFS_DATA0_LOW + 4'(2 * k), d[k]);
         acc(0, 0, 4'h0, 16'h0);
         chk(48'(flash_addr), 48'({hi[7:0], lo}));
         chk(flash_wdata, wexp());
         go(16'h0055, 16'h00aa, 0, OP_ERASE_PAGE, 1);
         go(16'h0055, 16'h00aa, 0, OP_PROGRAM_PAIR, 1);
         chk(flash_wdata, wexp());
      end
      go(16'h0000, 16'h0000, 0, OP_PROGRAM_PAIR, 0);
      go(16'h00aa, 16'h0055, 0, OP_PROGRAM_PAIR, 0);
      go(16'h0055, 16'h00aa, 1, OP_ERASE_PAGE, 0);
      go(16'h0055, 16'h00aa, 0, 4'h2, 0);
      go(16'h0055, 16'h00aa, 0, OP_ERASE_PAGE, 1);
      lo = lo ^ 16'h0002;
      acc(1, 0, OFS_ADDR_LOW, lo);
      go(16'h0055, 16'h00aa, 0, OP_PROGRAM_PAIR, 0);
      stop_test();
   end
endmodule : fsp_sequencer_bench
`default_nettype wire

//--- tb/fsp_sequencer_sva.sv
`timescale 1ns/10ps
`default_nettype none
module fsp_sequencer_sva
   import fsp_pkg::*;
#(parameter int ERASE_CNT = 20, parameter int PROGRAM_CNT = 5) (
   // Clock, reset and register port.
   input wire logic mclk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   // Processor and flash array.
   input wire logic cpu_stall,
   input wire logic flash_erase,
   input wire logic flash_program,
   input wire logic [EA_W-1:0] flash_addr,
   input wire logic [2*WORD_W-1:0] flash_wdata
);
   // ----
   // Last request and unlock tracking.
   // ----
   logic [DATA_W-1:0] wd_q;
   logic [ADDR_W-1:0] ad_q;
   logic wr_q, rd_q;
   logic [1:0] arm;
   wire logic key_w = reg_wr && reg_addr == OFS_KEY;
   wire logic [1:0] next_arm = !reg_wr ? arm
      : (key_w && reg_wdata[7:0] == KEY_FIRST) ? 2'h1
      : (key_w && arm == 2'h1 && reg_wdata[7:0] == KEY_SECOND) ? 2'h2 : 2'h0;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         {wd_q, ad_q, wr_q, rd_q, arm} <= '0;
      end else begin
         {wd_q, ad_q, wr_q, rd_q, arm} <= {reg_wdata, reg_addr, reg_wr, reg_rd, next_arm};
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   AST_STALL: assert property (cpu_stall == (flash_erase || flash_program))
      else $error("stall differs from operation flags");
   AST_ONE_OP: assert property (!(flash_erase && flash_program))
      else $error("erase and program at once");
   AST_ALIGN: assert property ($rose(flash_program) |-> flash_addr[1:0] == 2'b10)
      else $error("program started on a misaligned address");
   AST_START: assert property ($rose(cpu_stall) |-> wr_q && ad_q == OFS_CONTROL
      && wd_q[15] && flash_erase == (wd_q[3:0] == OP_ERASE_PAGE))
      else $error("operation started without a matching control write");
   AST_UNLOCK: assert property ((reg_wr && reg_addr == OFS_CONTROL && reg_wdata[15]
      && arm != 2'h2 && !cpu_stall) |=> !cpu_stall)
      else $error("operation started without unlock");
   AST_KEY_RD: assert property (reg_rd && reg_addr == OFS_KEY |=> reg_rdata == '0)
      else $error("key register read back nonzero");
   AST_RD_IDLE: assert property (!rd_q |-> reg_rdata == '0)
      else $error("read data outside read cycle");
   AST_ADDR_HI: assert property (reg_wr && reg_addr == OFS_ADDR_HIGH && !cpu_stall
      |=> flash_addr[23:16] == wd_q[7:0])
      else $error("high address not taken");
   AST_ADDR_LO: assert property (reg_wr && reg_addr == OFS_ADDR_LOW && !cpu_stall
      |=> flash_addr[15:0] == wd_q)
      else $error("low address not taken");
endmodule : fsp_sequencer_sva
bind fsp_sequencer fsp_sequencer_sva #(.ERASE_CNT(ERASE_CNT), .PROGRAM_CNT(PROGRAM_CNT)) i_sva (
   .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_stall(cpu_stall), .flash_erase(flash_erase),
   .flash_program(flash_program), .flash_addr(flash_addr), .flash_wdata(flash_wdata));
`default_nettype wire
